/* File: bsu_defines.vh */
`ifndef BSU_DEFINES_VH
`define BSU_DEFINES_VH

// Register byte addresses
`define BSU_CTRL_ADDR 16'hff14
`define BSU_STAT_ADDR 16'hff16

// On-chip register area, never stretched
`define BSU_ONCHIP_LO 16'hfe80

// Control register fields
`define BSU_MODE_HI 3
`define BSU_MODE_LO 2
`define BSU_COUNT_HI 1
`define BSU_COUNT_LO 0

// Control register reset value and fixed upper nibble
`define BSU_CTRL_RESET 8'hf3
`define BSU_CTRL_UPPER 4'hf
// Writable low nibble of the reset value
`define BSU_CTRL_RESET_LO 4'h3

// Stretch mode encodings
`define BSU_MODE_COUNT 2'h0
`define BSU_MODE_NONE 2'h1
`define BSU_MODE_EXTEND 2'h2
`define BSU_MODE_TRIGGER 2'h3

// Bus state encodings shown on BUS_STATE
`define BSU_ST_IDLE 3'h0
`define BSU_ST_T1 3'h1
`define BSU_ST_T2 3'h2
`define BSU_ST_TW 3'h3
`define BSU_ST_T3 3'h4

`endif

/* File: bsu_sync2.v */
`timescale 1ns/1ps

// Two-stage synchroniser for a pin level
module bsu_sync2
(
    input wire clk,
    input wire reset_n,
    input wire async_in,
    output reg sync_out
);

    // First stage, read only by the second stage
    reg meta;

    // Both stages reset high, the idle level of an active-low pin
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // bsu_sync2

/* File: bsu_top.v */
`timescale 1ns/1ps
`include "bsu_defines.vh"

// Function
// - Stretch only external three-state-space accesses
// - Extra states sit between T2 and T3
// - Upper nibble reserved, reads ones
// - Reset and hardware standby reinitialise control
// - Mode field bits 3:2 selects mode
// - Mode 01 never inserts extra states
// - Count field bits 1:0, resets to 3
// - Count mode inserts count, ignores pin
// - Extend mode adds states while pin low
// - Zero count, yet extend mode honours pin
// - Pin modes select wait function automatically
// - Trigger mode inserts count only if low
// - Trigger mode samples pin once in T2
// - Trigger mode ignores pin after T2
module bsu_top
(
    input wire CLK,
    input wire RESET_N,
    input wire HW_STANDBY,
    input wire [15:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    input wire BUS_START,
    input wire [15:0] BUS_ADDR,
    input wire BUS_EXT3,
    input wire WAIT_N,
    output reg [2:0] BUS_STATE,
    output reg STRETCH_ACTIVE,
    output reg WAIT_FUNC_SEL
);

    // Bus state codes, also shown on BUS_STATE
    // Binary codes; TW repeats while stretching
    localparam [2:0] st_idle = `BSU_ST_IDLE;
    localparam [2:0] st_t1 = `BSU_ST_T1;
    localparam [2:0] st_t2 = `BSU_ST_T2;
    localparam [2:0] st_tw = `BSU_ST_TW;
    localparam [2:0] st_t3 = `BSU_ST_T3;

    // Stored low nibble of the control register
    reg [3:0] ctrl;
    // Current bus state
    reg [2:0] state;
    // Next bus state
    reg [2:0] next_state;
    // Remaining programmed extra states
    reg [1:0] remain;
    // Next remaining count
    reg [1:0] next_remain;
    // Access in progress may be stretched
    reg qualify;
    // Next qualify flag
    reg next_qualify;
    // Wait pin after the synchroniser
    wire wait_n_sync;
    // Wait pin seen low
    wire wait_low;
    // Mode field
    wire [1:0] mode;
    // Count field
    wire [1:0] count;
    // Status byte: state, synced pin, stretch flag
    wire [7:0] status;

    assign mode = ctrl[`BSU_MODE_HI:`BSU_MODE_LO];
    assign count = ctrl[`BSU_COUNT_HI:`BSU_COUNT_LO];
    // The pin is looked at on the rising edge that ends T2, two
    // flip-flops after the pin; a slow device must pull it low
    // early enough in the access to be seen there.
    assign wait_low = ~wait_n_sync;

    // Decide whether an access may receive extra states
    function qualifies;
        input [15:0] addr;
        input ext3;
        begin
            // On-chip register area and two-state space excluded
            qualifies = ext3 && (addr < `BSU_ONCHIP_LO);
        end
    endfunction

    // Pin wait function in use for either pin mode
    function pin_mode;
        input [1:0] m;
        begin
            pin_mode = (m == `BSU_MODE_EXTEND) ||
                       (m == `BSU_MODE_TRIGGER);
        end
    endfunction

    // Decide whether a state code is an inserted extra state
    // Shared by the status byte and the stretch flag output
    function is_tw;
        input [2:0] s;
        begin
            is_tw = (s == st_tw);
        end
    endfunction

    // Status: bits 4:2 state, bit 1 synced pin, bit 0 in TW
    assign status = {3'h0, state, wait_n_sync, is_tw(state)};

    // Wait pin synchroniser
    bsu_sync2 u_wait_sync
    (
        .clk(CLK),
        .reset_n(RESET_N),
        .async_in(WAIT_N),
        .sync_out(wait_n_sync)
    );

    // Control register write, reset and hardware standby
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Initial value on reset
            ctrl <= `BSU_CTRL_RESET_LO;
        end
        else if (HW_STANDBY)
        begin
            // Hardware standby reinitialises; software standby does not
            ctrl <= `BSU_CTRL_RESET_LO;
        end
        else if (REG_WR && (REG_ADDR == `BSU_CTRL_ADDR))
        begin
            // Upper nibble cannot be written
            ctrl <= REG_WDATA[3:0];
        end
    end

    // Register read data, valid the cycle after the strobe
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Nothing to answer during reset
            REG_RDATA <= 8'h00;
        end
        else if (REG_RD)
        begin
            // Read strobe: answer stands in the next cycle
            case (REG_ADDR)
                `BSU_CTRL_ADDR:
                begin
                    // Reserved bits read as ones
                    REG_RDATA <= {`BSU_CTRL_UPPER, ctrl};
                end
                `BSU_STAT_ADDR:
                begin
                    // Stretch busy, synced pin level, state
                    REG_RDATA <= status;
                end
                default:
                begin
                    // Unmapped address reads zero
                    REG_RDATA <= 8'h00;
                end
            endcase
        end
        else
        begin
            // Data stands for one cycle only
            REG_RDATA <= 8'h00;
        end
    end

    // Bus state sequencing
    always @*
    begin
        // Hold everything unless a branch moves it
        next_state = state;
        next_remain = remain;
        next_qualify = qualify;
        case (state)
            st_idle:
            begin
                // Idle until an access begins
                if (BUS_START)
                begin
                    // Qualification fixed for the whole access
                    next_state = st_t1;
                    next_qualify = qualifies(BUS_ADDR, BUS_EXT3);
                end
            end
            st_t1:
            begin
                // T1 always leads to T2
                next_state = st_t2;
            end
            st_t2:
            begin
                // Decision point; extra states follow T2
                next_state = st_t3;
                next_remain = 2'h0;
                // Extra states only for qualifying accesses
                if (qualify)
                begin
                    // Mode read live at the decision
                    case (mode)
                        `BSU_MODE_COUNT:
                        begin
                            // Count only, pin not looked at
                            if (count != 2'h0)
                            begin
                                next_state = st_tw;
                                next_remain = count;
                            end
                        end
                        `BSU_MODE_NONE:
                        begin
                            // Never stretched, count ignored
                            next_state = st_t3;
                        end
                        `BSU_MODE_EXTEND:
                        begin
                            // Count first; low pin stretches even at zero
                            if ((count != 2'h0) || wait_low)
                            begin
                                next_state = st_tw;
                                next_remain = count;
                            end
                        end
                        `BSU_MODE_TRIGGER:
                        begin
                            // Single sample here decides the stretch
                            if (wait_low && (count != 2'h0))
                            begin
                                next_state = st_tw;
                                next_remain = count;
                            end
                        end
                        default:
                        begin
                            // Unreachable with a two-bit field
                            next_state = st_t3;
                        end
                    endcase
                end
            end
            st_tw:
            begin
                // Programmed count runs down first
                if (remain > 2'h1)
                begin
                    // More programmed states to go
                    next_remain = remain - 2'h1;
                end
                else if ((mode == `BSU_MODE_EXTEND) && wait_low)
                begin
                    // Keep adding states while the pin stays low
                    next_remain = 2'h0;
                end
                else
                begin
                    // Trigger mode ends here whatever the pin
                    next_state = st_t3;
                    next_remain = 2'h0;
                end
            end
            st_t3:
            begin
                // Back-to-back access may start at once
                if (BUS_START)
                begin
                    // Requalify the new access
                    next_state = st_t1;
                    next_qualify = qualifies(BUS_ADDR, BUS_EXT3);
                end
                else
                begin
                    // No new access: back to idle
                    next_state = st_idle;
                    next_qualify = 1'b0;
                end
            end
            default:
            begin
                // Recover from an unused code
                next_state = st_idle;
                next_remain = 2'h0;
                next_qualify = 1'b0;
            end
        endcase
    end

    // State registers
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Asynchronous reset to idle
            state <= st_idle;
            remain <= 2'h0;
            qualify <= 1'b0;
        end
        else if (HW_STANDBY)
        begin
            // Standby abandons any access
            state <= st_idle;
            remain <= 2'h0;
            qualify <= 1'b0;
        end
        else
        begin
            // Normal sequencing
            state <= next_state;
            remain <= next_remain;
            qualify <= next_qualify;
        end
    end

    // Registered outputs mirror the next state and the mode
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Asynchronous reset to idle outputs
            BUS_STATE <= st_idle;
            STRETCH_ACTIVE <= 1'b0;
            WAIT_FUNC_SEL <= 1'b0;
        end
        else if (HW_STANDBY)
        begin
            // Standby idles the outputs too
            BUS_STATE <= st_idle;
            STRETCH_ACTIVE <= 1'b0;
            WAIT_FUNC_SEL <= 1'b0;
        end
        else
        begin
            // Outputs follow the state being entered
            BUS_STATE <= next_state;
            STRETCH_ACTIVE <= is_tw(next_state);
            // Shared pin becomes the wait input in pin modes
            WAIT_FUNC_SEL <= pin_mode(mode);
        end
    end

    // Pin-triggered use expects outside logic to gate the pin
    // with the address strobe and a decoded select.

endmodule // bsu_top

/* File: bsu_checker.sv */
`timescale 1ns/1ps
`include "bsu_defines.vh"

// Port-level checks of the stretch unit
module bsu_checker
(
    input wire CLK,
    input wire RESET_N,
    input wire HW_STANDBY,
    input wire [15:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire BUS_START,
    input wire [15:0] BUS_ADDR,
    input wire BUS_EXT3,
    input wire WAIT_N,
    input wire [2:0] BUS_STATE,
    input wire STRETCH_ACTIVE,
    input wire WAIT_FUNC_SEL
);
    reg [3:0] ctl; // Mirror of mode and count fields
    reg qual; // Mirror of the current access qualification
    // Follow control writes and reinit
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ctl <= 4'h3;
        else if (HW_STANDBY)
            ctl <= 4'h3;
        else if (REG_WR && REG_ADDR == `BSU_CTRL_ADDR)
            ctl <= REG_WDATA[3:0];
    end
    // Follow the qualification of each accepted access
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            qual <= 1'b0;
        else if (HW_STANDBY)
            qual <= 1'b0;
        else if (BUS_START && (BUS_STATE == `BSU_ST_IDLE ||
                 BUS_STATE == `BSU_ST_T3))
            qual <= BUS_EXT3 && (BUS_ADDR < `BSU_ONCHIP_LO);
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N || HW_STANDBY);
    a_flag_in_tw: assert property
        (STRETCH_ACTIVE == (BUS_STATE == `BSU_ST_TW))
        else $error("stretch flag differs from state");
    a_tw_after_t2: assert property
        (BUS_STATE == `BSU_ST_TW |-> ($past(BUS_STATE) == `BSU_ST_T2 ||
        $past(BUS_STATE) == `BSU_ST_TW))
        else $error("extra state not after T2");
    a_unqual_no_tw: assert property
        (BUS_START && (BUS_STATE == `BSU_ST_IDLE ||
        BUS_STATE == `BSU_ST_T3) && (!BUS_EXT3 ||
        BUS_ADDR >= `BSU_ONCHIP_LO) |=> BUS_STATE == `BSU_ST_T1
        ##1 BUS_STATE == `BSU_ST_T2 ##1 BUS_STATE == `BSU_ST_T3)
        else $error("unqualified access stretched");
    a_rdata_idle: assert property
        (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside answer cycle");
    a_upper_ones: assert property
        ($past(REG_RD) && $past(REG_ADDR) == `BSU_CTRL_ADDR |->
        REG_RDATA[7:4] == 4'hf)
        else $error("reserved bits not ones");
    a_func_sel: assert property
        (WAIT_FUNC_SEL == $past(ctl[3]))
        else $error("wait function select wrong");
    a_none_mode: assert property
        (ctl[3:2] == 2'h1 && BUS_STATE == `BSU_ST_T2 |=>
        BUS_STATE == `BSU_ST_T3)
        else $error("mode none stretched");
    a_count_one: assert property
        (qual && ctl == 4'h1 && BUS_STATE == `BSU_ST_T2 |=>
        BUS_STATE == `BSU_ST_TW ##1 BUS_STATE == `BSU_ST_T3)
        else $error("count one not one state");
endmodule // bsu_checker

bind bsu_top bsu_checker bsu_checker_inst (.CLK(CLK), .RESET_N(RESET_N),
    .HW_STANDBY(HW_STANDBY), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .BUS_START(BUS_START), .BUS_ADDR(BUS_ADDR), .BUS_EXT3(BUS_EXT3),
    .WAIT_N(WAIT_N), .BUS_STATE(BUS_STATE), .STRETCH_ACTIVE(STRETCH_ACTIVE),
    .WAIT_FUNC_SEL(WAIT_FUNC_SEL));

/* File: bsu_slow_dev.sv */
`timescale 1ns/1ps
`include "bsu_defines.vh"

// Slow device: pulls the wait pin during its own accesses
module bsu_slow_dev
(
    input wire clk,
    input wire reset_n,
    input wire bus_start,
    input wire [15:0] bus_addr,
    input wire [2:0] bus_state,
    input wire hold,
    output wire wait_n
);
    wire hit; // Decoded address of this device
    reg busy; // Own access in flight
    assign hit = bus_start && bus_addr[15:12] == 4'h8;
    // Strobe and decode latched until T3
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            busy <= 1'b0;
        else if (bus_start)
            busy <= hit;
        else if (bus_state == `BSU_ST_T3)
            busy <= 1'b0;
    end
    // Low while selected, or while the bench holds it
    assign wait_n = !(hold || busy || hit);
endmodule // bsu_slow_dev

/* File: tb.sv */
`timescale 1ns/1ps
`include "bsu_defines.vh"
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin \
    failures++; $display("FAIL %s exp %h got %h", n, e, v); end end

// Register and bus-cycle tests of the stretch unit
module tb;
    reg CLK = 0, RESET_N = 0, HW_STANDBY = 0, REG_WR = 0, REG_RD = 0;
    reg BUS_START = 0, BUS_EXT3 = 0, hold = 0;
    reg [15:0] REG_ADDR = 0, BUS_ADDR = 0;
    reg [7:0] REG_WDATA = 0, d;
    wire [7:0] REG_RDATA;
    wire [2:0] BUS_STATE;
    wire STRETCH_ACTIVE, WAIT_FUNC_SEL, WAIT_N;
    integer failures = 0, checks_done = 0, tw, i, j;
    always #5 CLK = ~CLK;
    bsu_top bsu_top_inst (.CLK(CLK), .RESET_N(RESET_N),
        .HW_STANDBY(HW_STANDBY), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .BUS_START(BUS_START), .BUS_ADDR(BUS_ADDR), .BUS_EXT3(BUS_EXT3),
        .WAIT_N(WAIT_N), .BUS_STATE(BUS_STATE),
        .STRETCH_ACTIVE(STRETCH_ACTIVE), .WAIT_FUNC_SEL(WAIT_FUNC_SEL));
    bsu_slow_dev bsu_slow_dev_inst (.clk(CLK), .reset_n(RESET_N),
        .bus_start(BUS_START), .bus_addr(BUS_ADDR), .bus_state(BUS_STATE),
        .hold(hold), .wait_n(WAIT_N));
    // Verdict and end of run
    task wrap_up;
    begin
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // One-cycle register write
    task wr(input [15:0] a, input [7:0] v);
    begin
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    end
    endtask
    // Register read, data taken in the answer cycle
    task rd(input [15:0] a);
    begin
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    end
    endtask
    // One bus access, counting extra states up to T3
    task acc(input [15:0] a, input e);
    begin
        tw = 0;
        @(posedge CLK);
        BUS_ADDR <= a;
        BUS_EXT3 <= e;
        BUS_START <= 1'b1;
        @(posedge CLK);
        BUS_START <= 1'b0;
        // Let the launched state settle before looking at it
        #1;
        for (i = 0; i < 200 && BUS_STATE !== `BSU_ST_T3; i++)
        begin
            @(posedge CLK);
            #1;
            if (STRETCH_ACTIVE === 1'b1)
                tw++;
        end
        if (i == 200)
        begin
            failures++;
            wrap_up;
        end
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(`BSU_CTRL_ADDR);
        `CHK("reset ctrl", 8'hf3, d)
        `CHK("func sel", 1'b0, WAIT_FUNC_SEL)
        rd(16'h0000);
        `CHK("unmapped", 8'h00, d)
        rd(`BSU_STAT_ADDR);
        `CHK("status idle", 8'h02, d)
        $display("test registers done");
        for (j = 0; j < 4; j++)
        begin
            wr(`BSU_CTRL_ADDR, j);
            acc(16'h1000, 1'b1);
            `CHK("count states", j, tw)
        end
        hold <= 1'b1;
        wr(`BSU_CTRL_ADDR, 8'h02);
        acc(16'h1000, 1'b1);
        `CHK("pin ignored", 2, tw)
        rd(`BSU_CTRL_ADDR);
        `CHK("upper ones", 8'hf2, d)
        hold <= 1'b0;
        wr(`BSU_CTRL_ADDR, 8'h07);
        acc(16'h1000, 1'b1);
        `CHK("mode none", 0, tw)
        wr(`BSU_CTRL_ADDR, 8'h03);
        acc(16'h1000, 1'b0);
        `CHK("two state space", 0, tw)
        acc(`BSU_ONCHIP_LO, 1'b1);
        `CHK("on-chip area", 0, tw)
        $display("test count modes done");
        wr(`BSU_CTRL_ADDR, 8'h0e);
        acc(16'h8000, 1'b1);
        `CHK("trigger low", 2, tw)
        acc(16'h1000, 1'b1);
        `CHK("trigger high", 0, tw)
        `CHK("func sel pin", 1'b1, WAIT_FUNC_SEL)
        wr(`BSU_CTRL_ADDR, 8'h09);
        acc(16'h1000, 1'b1);
        `CHK("extend no pin", 1, tw)
        wr(`BSU_CTRL_ADDR, 8'h08);
        hold <= 1'b1;
        fork
            acc(16'h1000, 1'b1);
            begin
                repeat (20) @(posedge CLK);
                hold <= 1'b0;
            end
        join
        // Pin low for 20 edges, seen two edges late, T1 and T2 first
        `CHK("extend held", 19, tw)
        $display("test pin modes done");
        wr(`BSU_CTRL_ADDR, 8'h05);
        HW_STANDBY <= 1'b1;
        @(posedge CLK);
        HW_STANDBY <= 1'b0;
        rd(`BSU_CTRL_ADDR);
        `CHK("standby ctrl", 8'hf3, d)
        $display("test standby done");
        wrap_up;
    end
endmodule // tb
